// file: hw/reset_source_and_brownout_control.sv
// Purpose: reset sequencing, cold-start flag and brown-out handling
// Assumes: all inputs synchronous to clk_i; supply_below_i is the comparator
// Notes:   Wishbone slave, one wait state, unmapped reads return zero
// Behaviour
// - five reset sources: power-up, pin, software, watchdog, brown-out; all drive core reset
// - any reset reloads control registers; cause flags depend on the source
// - core held in reset while supply-good is low; no fetches
// - after supply good, oscillator starts, then core released to fetch from zero
// - cold-reset flag set to one when power-on reset completes
// - cold-reset flag unchanged by every reset other than power-on
// - software may write the cold-reset flag, setting or clearing it
// - during reset port 1 bits 0,1,6,7 forced quasi-bidirectional
// - brown-out reset enable one: either crossing resets the core
// - brown-out reset enable zero: crossing sets brown-out flag, no reset
// - hardware sets flag; irq when flag, brown-out and global enables set
// - every reset loads detect enable from inverted config; zero disables detection
// - every reset loads level select from inverted config level bit
// - supply monitor control writable only inside an unlocked timed-access window
// - flag cleared while supply stays low is not set again until recovery
module reset_source_and_brownout_control
  import rst_ctrl_pkg::*;
#(
  parameter logic [15:0] OSC_CYCLES  = OSC_START_CYCLES,
  parameter logic [15:0] HOLD_CYCLES = RESET_HOLD_CYCLES,
  parameter logic [15:0] TA_CYCLES   = TA_WINDOW_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        supply_good_i,
  input  wire logic        supply_below_i,
  input  wire logic        pin_reset_i,
  input  wire logic        watchdog_reset_i,
  input  wire logic        cfg_brownout_detect_disable_i,
  input  wire logic        cfg_brownout_level_i,
  input  wire logic        cfg_brownout_reset_i,
  output logic             core_reset_o,
  output logic             osc_enable_o,
  output logic [7:0]       port1_quasi_force_o,
  output logic             brownout_detect_enable_o,
  output logic             brownout_level_select_o,
  output logic             brownout_irq_o,
  output logic             irq_o
);

  typedef struct packed {
    phase_e          phase;
    logic [15:0]     cnt;
    logic [7:0]      pwr_ctrl;
    logic            cold_reset_flag;
    logic            brownout_detect_enable;
    logic            brownout_level_select;
    logic            brownout_reset_enable;
    logic            brownout_flag;
    logic            global_irq_enable;
    logic            brownout_irq_enable;
    ta_e             ta;
    logic [15:0]     ta_cnt;
    logic            below_prev;
    logic [2:0]      cause;
    logic [EV_W-1:0] sts;
    logic [EV_W-1:0] msk;
    logic            core_rst;
    logic            osc_en;
    logic [7:0]      force_q;
    logic            bod_irq;
    logic            irq;
    logic            ack;
    logic [31:0]     dat;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic       bus_req;
  logic       bus_wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       running;
  logic       crossing;
  logic       ta_open;
  logic       sw_req;
  logic [7:0] supply_mon_rd;

  assign bus_req  = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign bus_wr   = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i[11:10] == 2'h0);
  assign idx      = wb_adr_i[9:2];
  assign wbyte    = wb_dat_i[7:0];
  assign running  = (st_reg.phase == PH_RUN);
  // edge of the comparator, so a low supply sets the flag only once
  assign crossing = running & st_reg.brownout_detect_enable &
                    (supply_below_i != st_reg.below_prev);
  assign ta_open  = (st_reg.ta == TA_OPEN);
  assign sw_req   = bus_wr & running & ta_open & (idx == SW_RESET_IDX) & wbyte[0];

  always_comb begin
    supply_mon_rd               = 8'h00;
    supply_mon_rd[BOD_EN_BIT]   = st_reg.brownout_detect_enable;
    supply_mon_rd[BOD_LVL_BIT]  = st_reg.brownout_level_select;
    supply_mon_rd[BOD_RST_BIT]  = st_reg.brownout_reset_enable;
    supply_mon_rd[BOD_FLAG_BIT] = st_reg.brownout_flag;
  end

  always_comb begin
    st_next            = st_reg;
    st_next.ack        = bus_req;
    st_next.below_prev = supply_below_i;

    // timed-access window ages out
    if (st_reg.ta != TA_IDLE) begin
      if (st_reg.ta_cnt == 16'h0000) begin
        st_next.ta = TA_IDLE;
      end else begin
        st_next.ta_cnt = st_reg.ta_cnt - 16'h0001;
      end
    end

    // software writes, only while the core runs
    if (bus_wr && running) begin
      unique case (idx)
        PWR_CTRL_IDX: begin
          st_next.pwr_ctrl        = wbyte & PWR_CTRL_WMASK;
          st_next.cold_reset_flag = wbyte[COLD_FLAG_BIT];
        end
        SUPPLY_MON_IDX: begin
          st_next.ta = TA_IDLE;
          if (ta_open) begin
            st_next.brownout_detect_enable = wbyte[BOD_EN_BIT];
            st_next.brownout_level_select  = wbyte[BOD_LVL_BIT];
            st_next.brownout_reset_enable  = wbyte[BOD_RST_BIT];
            st_next.brownout_flag          = wbyte[BOD_FLAG_BIT];
            // bits 5, 2, 1 and 0 are not stored and read zero
          end
        end
        TA_KEY_IDX: begin
          // second key must follow within the window with no other key write between, then one protected write
          if (wbyte == TA_KEY_FIRST) begin
            st_next.ta     = TA_ARMED;
            st_next.ta_cnt = TA_CYCLES;
          end else if (st_reg.ta == TA_ARMED && wbyte == TA_KEY_SECOND) begin
            st_next.ta     = TA_OPEN;
            st_next.ta_cnt = TA_CYCLES;
          end else begin
            st_next.ta = TA_IDLE;
          end
        end
        IRQ_EN_IDX: begin
          st_next.global_irq_enable   = wbyte[GLOBAL_IE_BIT];
          st_next.brownout_irq_enable = wbyte[BOD_IE_BIT];
        end
        SW_RESET_IDX: begin
          st_next.ta = TA_IDLE;
        end
        STATUS_IDX: begin
          st_next.sts = st_reg.sts & ~wbyte[EV_W-1:0];
        end
        MASK_IDX: begin
          st_next.msk = wbyte[EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // hardware sets after software clears, so a same-cycle event survives
    if (crossing) begin
      st_next.sts[EV_BROWNOUT] = 1'b1;
      if (!st_reg.brownout_reset_enable) begin
        st_next.brownout_flag = 1'b1;
      end
    end

    // reset sequencing, all sources funnel into one core reset
    unique case (st_reg.phase)
      PH_POR: begin
        st_next.cause = CAUSE_POR;
        if (supply_good_i) begin
          st_next.phase = PH_OSC;
          st_next.cnt   = OSC_CYCLES;
        end
      end
      PH_OSC: begin
        if (!supply_good_i) begin
          st_next.phase = PH_POR;
        end else if (st_reg.cnt == 16'h0000) begin
          // release: the core starts fetching from address zero
          st_next.phase           = PH_RUN;
          st_next.cold_reset_flag = 1'b1;
          st_next.sts[EV_COLD]    = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt - 16'h0001;
        end
      end
      PH_HOLD: begin
        if (!supply_good_i) begin
          st_next.phase = PH_POR;
        end else if (pin_reset_i || watchdog_reset_i) begin
          st_next.cnt = HOLD_CYCLES;
        end else if (st_reg.cnt == 16'h0000) begin
          st_next.phase = PH_RUN;
        end else begin
          st_next.cnt = st_reg.cnt - 16'h0001;
        end
      end
      PH_RUN: begin
        if (!supply_good_i) begin
          st_next.phase = PH_POR;
          st_next.cause = CAUSE_POR;
        end else if (pin_reset_i || watchdog_reset_i || sw_req ||
                     (crossing && st_reg.brownout_reset_enable)) begin
          // warm reset leaves the cold flag alone
          st_next.phase        = PH_HOLD;
          st_next.cnt          = HOLD_CYCLES;
          st_next.sts[EV_WARM] = 1'b1;
          if (pin_reset_i) begin
            st_next.cause = CAUSE_PIN;
          end else if (watchdog_reset_i) begin
            st_next.cause = CAUSE_WDT;
          end else if (sw_req) begin
            st_next.cause = CAUSE_SW;
          end else begin
            st_next.cause = CAUSE_BOD;
          end
        end
      end
    endcase

    // while in reset the control registers return to their defaults
    if (st_next.phase != PH_RUN) begin
      st_next.pwr_ctrl               = PWR_CTRL_RST;
      st_next.brownout_detect_enable = ~cfg_brownout_detect_disable_i;
      st_next.brownout_level_select  = ~cfg_brownout_level_i;
      st_next.brownout_reset_enable  = cfg_brownout_reset_i;
      st_next.global_irq_enable      = 1'b0;
      st_next.brownout_irq_enable    = 1'b0;
      st_next.ta                     = TA_IDLE;
    end

    st_next.core_rst = (st_next.phase != PH_RUN);
    st_next.osc_en   = (st_next.phase != PH_POR);
    st_next.force_q  = st_next.core_rst ? PORT1_FORCE : 8'h00;
    st_next.bod_irq  = st_next.brownout_flag & st_next.brownout_irq_enable &
                       st_next.global_irq_enable;
    st_next.irq      = |(st_next.sts & st_next.msk);

    // read data, zero for unmapped indexes
    st_next.dat = 32'h0000_0000;
    if (bus_req && !wb_we_i && wb_adr_i[11:10] == 2'h0) begin
      unique case (idx)
        PWR_CTRL_IDX: begin
          st_next.dat[7:0] = st_reg.pwr_ctrl |
                             {3'h0, st_reg.cold_reset_flag, 4'h0};
        end
        SUPPLY_MON_IDX: st_next.dat[7:0] = supply_mon_rd;
        IRQ_EN_IDX: begin
          st_next.dat[GLOBAL_IE_BIT] = st_reg.global_irq_enable;
          st_next.dat[BOD_IE_BIT]    = st_reg.brownout_irq_enable;
        end
        CAUSE_IDX:  st_next.dat[2:0] = st_reg.cause;
        STATUS_IDX: st_next.dat[EV_W-1:0] = st_reg.sts;
        MASK_IDX:   st_next.dat[EV_W-1:0] = st_reg.msk;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.phase                  <= PH_POR;
      st_reg.cnt                    <= 16'h0000;
      st_reg.pwr_ctrl               <= PWR_CTRL_RST;
      st_reg.cold_reset_flag        <= 1'b0;
      st_reg.brownout_detect_enable <= 1'b0;
      st_reg.brownout_level_select  <= 1'b0;
      st_reg.brownout_reset_enable  <= 1'b0;
      st_reg.brownout_flag          <= 1'b0;
      st_reg.global_irq_enable      <= 1'b0;
      st_reg.brownout_irq_enable    <= 1'b0;
      st_reg.ta                     <= TA_IDLE;
      st_reg.ta_cnt                 <= 16'h0000;
      st_reg.below_prev             <= 1'b0;
      st_reg.cause                  <= CAUSE_NONE;
      st_reg.sts                    <= 3'h0;
      st_reg.msk                    <= 3'h0;
      st_reg.core_rst               <= 1'b1;
      st_reg.osc_en                 <= 1'b0;
      st_reg.force_q                <= PORT1_FORCE;
      st_reg.bod_irq                <= 1'b0;
      st_reg.irq                    <= 1'b0;
      st_reg.ack                    <= 1'b0;
      st_reg.dat                    <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o                 = st_reg.ack;
  assign wb_dat_o                 = st_reg.dat;
  assign core_reset_o             = st_reg.core_rst;
  assign osc_enable_o             = st_reg.osc_en;
  assign port1_quasi_force_o      = st_reg.force_q;
  assign brownout_detect_enable_o = st_reg.brownout_detect_enable;
  assign brownout_level_select_o  = st_reg.brownout_level_select;
  assign brownout_irq_o           = st_reg.bod_irq;
  assign irq_o                    = st_reg.irq;

  a_por_holds_core: assert property (@(posedge clk_i) disable iff (rst_i)
    !supply_good_i |=> core_reset_o && !osc_enable_o)
    else $error("core not held while supply low");

  a_release_sets_cold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.phase == PH_OSC && st_reg.cnt == 16'h0000 && supply_good_i)
      |=> !core_reset_o && st_reg.cold_reset_flag)
    else $error("cold flag not set at power-on release");

  a_warm_keeps_cold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.phase == PH_HOLD && supply_good_i) |=> $stable(st_reg.cold_reset_flag))
    else $error("cold flag changed by warm reset");

  a_port_force_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    port1_quasi_force_o == (core_reset_o ? PORT1_FORCE : 8'h00))
    else $error("port force does not follow reset");

  a_bod_reset_core: assert property (@(posedge clk_i) disable iff (rst_i)
    (crossing && st_reg.brownout_reset_enable && supply_good_i)
      |=> core_reset_o ##1 core_reset_o)
    else $error("brown-out crossing did not reset");

  a_bod_flag_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (crossing && !st_reg.brownout_reset_enable && supply_good_i && !pin_reset_i
     && !watchdog_reset_i && !sw_req) |=> st_reg.brownout_flag && !core_reset_o)
    else $error("brown-out flag wrong without reset enable");

  a_bod_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    brownout_irq_o |-> st_reg.brownout_flag && st_reg.global_irq_enable
                       && st_reg.brownout_irq_enable)
    else $error("brown-out irq without flag and enables");

  a_cfg_enable_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.phase == PH_HOLD) |=> brownout_detect_enable_o ==
      !$past(cfg_brownout_detect_disable_i))
    else $error("detect enable not loaded from config");

  a_cfg_level_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.phase == PH_POR) |=> brownout_level_select_o ==
      !$past(cfg_brownout_level_i))
    else $error("level select not loaded from config");

  a_locked_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_wr && idx == SUPPLY_MON_IDX && !ta_open && !crossing
     && running && supply_good_i && !pin_reset_i && !watchdog_reset_i)
      |=> $stable(supply_mon_rd))
    else $error("locked supply monitor register changed");

  a_cold_sw_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_wr && running && idx == PWR_CTRL_IDX && st_next.phase == PH_RUN)
      |=> st_reg.cold_reset_flag == $past(wb_dat_i[COLD_FLAG_BIT]))
    else $error("cold flag not written by software");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.brownout_flag && !(bus_wr && running && ta_open && idx == SUPPLY_MON_IDX))
      |=> st_reg.brownout_flag)
    else $error("brown-out flag cleared without software");

  a_key_opens_window: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_wr && running && idx == TA_KEY_IDX && wbyte == TA_KEY_SECOND
     && st_reg.ta == TA_ARMED && st_next.phase == PH_RUN) |=> ta_open)
    else $error("key pair did not open the window");

endmodule : reset_source_and_brownout_control

// file: inc/rst_ctrl_pkg.sv
// Purpose: shared constants for the reset source and brown-out controller
// Assumes: 25 MHz system clock, classic Wishbone with 32-bit data
// Notes:   register byte address is four times the register index
package rst_ctrl_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned OSC_START_NS     = 2000;
  localparam int unsigned RESET_HOLD_NS    = 480;
  localparam int unsigned TA_WINDOW_NS     = 320;
  localparam logic [15:0] OSC_START_CYCLES =
    16'((OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RESET_HOLD_CYCLES =
    16'((RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] TA_WINDOW_CYCLES =
    16'((TA_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register indexes
  localparam logic [7:0] PWR_CTRL_IDX   = 8'h87;
  localparam logic [7:0] SUPPLY_MON_IDX = 8'ha3;
  localparam logic [7:0] TA_KEY_IDX     = 8'hc7;
  localparam logic [7:0] IRQ_EN_IDX     = 8'hd0;
  localparam logic [7:0] SW_RESET_IDX   = 8'hd1;
  localparam logic [7:0] CAUSE_IDX      = 8'hd2;
  localparam logic [7:0] STATUS_IDX     = 8'hd3;
  localparam logic [7:0] MASK_IDX       = 8'hd4;

  // power_and_cold_reset_control fields
  localparam int unsigned COLD_FLAG_BIT  = 4;
  localparam logic [7:0]  PWR_CTRL_WMASK = 8'hcf;
  localparam logic [7:0]  PWR_CTRL_RST   = 8'h00;

  // supply_monitor_control fields
  localparam int unsigned BOD_EN_BIT   = 7;
  localparam int unsigned BOD_LVL_BIT  = 6;
  localparam int unsigned BOD_RST_BIT  = 4;
  localparam int unsigned BOD_FLAG_BIT = 3;

  // irq enable fields
  localparam int unsigned GLOBAL_IE_BIT = 7;
  localparam int unsigned BOD_IE_BIT    = 5;

  // status / mask fields
  localparam int unsigned EV_BROWNOUT = 0;
  localparam int unsigned EV_COLD     = 1;
  localparam int unsigned EV_WARM     = 2;
  localparam int unsigned EV_W        = 3;

  // reset cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_POR  = 3'h1;
  localparam logic [2:0] CAUSE_PIN  = 3'h2;
  localparam logic [2:0] CAUSE_SW   = 3'h3;
  localparam logic [2:0] CAUSE_WDT  = 3'h4;
  localparam logic [2:0] CAUSE_BOD  = 3'h5;

  localparam logic [7:0] TA_KEY_FIRST  = 8'haa;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [7:0] PORT1_FORCE   = 8'hc3;

  typedef enum logic [1:0] {PH_POR, PH_OSC, PH_HOLD, PH_RUN} phase_e;
  typedef enum logic [1:0] {TA_IDLE, TA_ARMED, TA_OPEN} ta_e;

endpackage : rst_ctrl_pkg

// file: bench/test_reset_source_and_brownout_control.sv
// Purpose: self-checking bench for the reset source and brown-out controller
// Assumes: short oscillator and hold counts so the run stays brief
// Notes:   registers reached by classic Wishbone single cycles only
module test_reset_source_and_brownout_control import rst_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_data;
  logic [3:0]  wb_sel_i;
  logic        supply_good_i, supply_below_i, pin_reset_i, watchdog_reset_i;
  logic        cfg_brownout_detect_disable_i, cfg_brownout_level_i, cfg_brownout_reset_i;
  logic        core_reset_o, osc_enable_o, brownout_detect_enable_o;
  logic        brownout_level_select_o, brownout_irq_o, irq_o;
  logic [7:0]  port1_quasi_force_o;
  logic [2:0]  cause_exp [3] = '{CAUSE_PIN, CAUSE_WDT, CAUSE_SW};
  int          err_count = 0;
  int          checked = 0;
  // byte lanes of the next transfer; lane zero off must drop a write
  logic [3:0]  sel_use = 4'h1;

  reset_source_and_brownout_control #(
    .OSC_CYCLES(16'h0002), .HOLD_CYCLES(16'h0002), .TA_CYCLES(16'h0008)
  ) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_good_i(supply_good_i),
    .supply_below_i(supply_below_i), .pin_reset_i(pin_reset_i),
    .watchdog_reset_i(watchdog_reset_i),
    .cfg_brownout_detect_disable_i(cfg_brownout_detect_disable_i),
    .cfg_brownout_level_i(cfg_brownout_level_i), .cfg_brownout_reset_i(cfg_brownout_reset_i),
    .core_reset_o(core_reset_o), .osc_enable_o(osc_enable_o),
    .port1_quasi_force_o(port1_quasi_force_o),
    .brownout_detect_enable_o(brownout_detect_enable_o),
    .brownout_level_select_o(brownout_level_select_o), .brownout_irq_o(brownout_irq_o),
    .irq_o(irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // request held until ack is sampled high, then one idle edge
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                         output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= sel_use;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d, rd_data);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00, rd_data);
    chk(rd_data, {24'h0, exp}, "register read");
  endtask : rd_chk

  // protected write must follow the key pair before the window ages out
  task automatic prot_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(TA_KEY_IDX, TA_KEY_FIRST);
    wr(TA_KEY_IDX, TA_KEY_SECOND);
    wr(idx, d);
  endtask : prot_wr

  task automatic wait_core(input logic lvl, input int lim);
    int n;
    n = 0;
    while (core_reset_o !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(core_reset_o), 32'(lvl), "core reset level");
  endtask : wait_core

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, pin_reset_i, watchdog_reset_i} = 5'h00;
    wb_adr_i = 12'h000;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    {supply_good_i, supply_below_i} = 2'b00;
    cfg_brownout_detect_disable_i = 1'b0;
    cfg_brownout_level_i = 1'b0;
    cfg_brownout_reset_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(32'(core_reset_o), 32'h1, "held without supply");
    chk(32'(osc_enable_o), 32'h0, "oscillator off");
    chk(32'(port1_quasi_force_o), 32'(PORT1_FORCE), "port force");
    supply_good_i <= 1'b1;
    for (int i = 0; i < 10 && osc_enable_o !== 1'b1; i++) @(posedge clk_i);
    chk(32'(core_reset_o), 32'h1, "held while oscillator starts");
    wait_core(1'b0, 20);
    chk(32'(port1_quasi_force_o), 32'h0, "port force off");
    rd_chk(PWR_CTRL_IDX, 8'h10);
    rd_chk(CAUSE_IDX, {5'h0, CAUSE_POR});
    rd_chk(SUPPLY_MON_IDX, 8'hc0);
    chk(32'(brownout_level_select_o), 32'h1, "level select");
    rd_chk(STATUS_IDX, 8'h02);
    $display("test power_on done");

    wr(PWR_CTRL_IDX, 8'hff);
    rd_chk(PWR_CTRL_IDX, 8'hdf);
    wr(PWR_CTRL_IDX, 8'h00);
    rd_chk(PWR_CTRL_IDX, 8'h00);
    sel_use = 4'h2;
    wr(PWR_CTRL_IDX, 8'hff);
    sel_use = 4'h1;
    rd_chk(PWR_CTRL_IDX, 8'h00);
    rd_chk(8'h55, 8'h00);
    wr(STATUS_IDX, 8'h07);
    rd_chk(STATUS_IDX, 8'h00);
    wr(SUPPLY_MON_IDX, 8'h00);
    rd_chk(SUPPLY_MON_IDX, 8'hc0);
    prot_wr(SUPPLY_MON_IDX, 8'h80);
    rd_chk(SUPPLY_MON_IDX, 8'h80);
    wr(SUPPLY_MON_IDX, 8'h00);
    rd_chk(SUPPLY_MON_IDX, 8'h80);
    wr(TA_KEY_IDX, TA_KEY_SECOND);
    wr(SUPPLY_MON_IDX, 8'h00);
    rd_chk(SUPPLY_MON_IDX, 8'h80);
    $display("test registers done");

    wr(IRQ_EN_IDX, 8'ha0);
    wr(MASK_IDX, 8'h01);
    supply_below_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(brownout_irq_o), 32'h1, "brown-out irq");
    chk(32'(irq_o), 32'h1, "masked irq");
    chk(32'(core_reset_o), 32'h0, "no reset");
    rd_chk(SUPPLY_MON_IDX, 8'h88);
    prot_wr(SUPPLY_MON_IDX, 8'h80);
    repeat (6) @(posedge clk_i);
    rd_chk(SUPPLY_MON_IDX, 8'h80);
    chk(32'(brownout_irq_o), 32'h0, "irq after clear");
    wr(STATUS_IDX, 8'h01);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0, "status cleared");
    supply_below_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(SUPPLY_MON_IDX, 8'h88);
    chk(32'(irq_o), 32'h1, "rising crossing irq");
    wr(MASK_IDX, 8'h00);
    wr(IRQ_EN_IDX, 8'h20);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0, "masked off");
    chk(32'(brownout_irq_o), 32'h0, "global enable off");
    prot_wr(SUPPLY_MON_IDX, 8'h00);
    wr(STATUS_IDX, 8'h07);
    chk(32'(brownout_detect_enable_o), 32'h0, "detect disabled");
    supply_below_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(SUPPLY_MON_IDX, 8'h00);
    supply_below_i <= 1'b0;
    $display("test brown-out flag done");

    cfg_brownout_level_i <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      wr(PWR_CTRL_IDX, 8'h0f);
      if (s == 0) pin_reset_i <= 1'b1;
      if (s == 1) watchdog_reset_i <= 1'b1;
      if (s == 2) prot_wr(SW_RESET_IDX, 8'h01);
      wait_core(1'b1, 6);
      chk(32'(port1_quasi_force_o), 32'(PORT1_FORCE), "port force warm");
      pin_reset_i <= 1'b0;
      watchdog_reset_i <= 1'b0;
      wait_core(1'b0, 30);
      rd_chk(PWR_CTRL_IDX, 8'h00);
      rd_chk(CAUSE_IDX, {5'h0, cause_exp[s]});
      rd_chk(SUPPLY_MON_IDX, 8'h80);
      chk(32'(brownout_level_select_o), 32'h0, "level reload");
    end
    $display("test warm resets done");

    prot_wr(SUPPLY_MON_IDX, 8'h90);
    supply_below_i <= 1'b1;
    wait_core(1'b1, 6);
    wait_core(1'b0, 30);
    rd_chk(CAUSE_IDX, {5'h0, CAUSE_BOD});
    rd_chk(SUPPLY_MON_IDX, 8'h80);
    prot_wr(SUPPLY_MON_IDX, 8'h90);
    supply_below_i <= 1'b0;
    wait_core(1'b1, 6);
    wait_core(1'b0, 30);
    rd_chk(PWR_CTRL_IDX, 8'h00);
    $display("test brown-out reset done");

    cfg_brownout_detect_disable_i <= 1'b1;
    cfg_brownout_level_i <= 1'b0;
    cfg_brownout_reset_i <= 1'b1;
    supply_good_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(core_reset_o), 32'h1, "held on supply loss");
    chk(32'(osc_enable_o), 32'h0, "oscillator off on supply loss");
    supply_good_i <= 1'b1;
    wait_core(1'b0, 20);
    rd_chk(PWR_CTRL_IDX, 8'h10);
    rd_chk(CAUSE_IDX, {5'h0, CAUSE_POR});
    rd_chk(SUPPLY_MON_IDX, 8'h50);
    chk(32'(brownout_detect_enable_o), 32'h0, "detect off from config");
    chk(32'(brownout_level_select_o), 32'h1, "level from config");
    $display("test power cycle done");
    repeat (2) @(posedge clk_i);
    final_report();
  end
endmodule : test_reset_source_and_brownout_control
